//--- core/pwmceb_blank.sv
// Leading-edge blanking unit that qualifies fault and current-limit inputs
`timescale 1ns/1ps
module pwmceb_blank
  import pwmceb_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  pwmceb_blank_if.blank bi
);
  typedef struct packed {
    logic hi_d;
    logic lo_d;
    logic [CNT_W-1:0] cnt;
  } pwmceb_blank_st_t;
  pwmceb_blank_st_t st_reg, st_next;
  logic trig;
  logic blank;
  logic [15:0] c;
  always_comb begin
    c = bi.blank_ctrl;
    st_next = st_reg;
    st_next.hi_d = bi.high_out;
    st_next.lo_d = bi.low_out;
    trig = (c[B_PHR] && bi.high_out && !st_reg.hi_d) ||
           (c[B_PHF] && !bi.high_out && st_reg.hi_d) ||
           (c[B_PLR] && bi.low_out && !st_reg.lo_d) ||
           (c[B_PLF] && !bi.low_out && st_reg.lo_d);
    if (trig) begin
      st_next.cnt = bi.blank_len;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CNT_ONE;
    end
    blank = (st_reg.cnt != '0) ||
            (c[B_BCH] && bi.blank_sel_level) || (c[B_BCL] && !bi.blank_sel_level) ||
            (c[B_BLANK_WHILE_HIGH_OUT_HIGH] && bi.high_out) || (c[B_BLANK_WHILE_HIGH_OUT_LOW] && !bi.high_out) ||
            (c[B_BPLH] && bi.low_out) || (c[B_BPLL] && !bi.low_out);
    bi.fault_q = bi.fault_raw && !(c[B_FLTLEB] && blank);
    bi.curlim_q = bi.curlim_raw && !(c[B_CLLEB] && blank);
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : pwmceb_blank

//--- core/pwmceb_blank_if.sv
// Interface between generator core and blanking unit
`timescale 1ns/1ps
interface pwmceb_blank_if;
  logic high_out;
  logic low_out;
  logic [15:0] blank_ctrl;
  logic [15:0] blank_len;
  logic blank_sel_level;
  logic fault_raw;
  logic curlim_raw;
  logic fault_q;
  logic curlim_q;
  modport core (output high_out, output low_out, output blank_ctrl, output blank_len, output blank_sel_level,
                output fault_raw, output curlim_raw, input fault_q, input curlim_q);
  modport blank (input high_out, input low_out, input blank_ctrl, input blank_len, input blank_sel_level,
                 input fault_raw, input curlim_raw, output fault_q, output curlim_q);
endinterface : pwmceb_blank_if

//--- core/pwmceb_pkg.sv
// Package with register map, field positions and modes of the PWM control and blanking block
package pwmceb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int SRC_W = 16;
  localparam logic [ADDR_W-1:0] OFS_GEN_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_BLANK_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_AUX_CTRL = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PHASE = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_DEAD = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_BLANK_LEN = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'ha;
  localparam logic [DATA_W-1:0] RST_VAL = 16'h0000;
  localparam logic [DATA_W-1:0] GEN_CTRL_MASK = 16'h82cf;
  localparam logic [DATA_W-1:0] BLANK_CTRL_MASK = 16'hfc3f;
  localparam logic [DATA_W-1:0] AUX_CTRL_MASK = 16'h000f;
  // Generator control fields
  localparam int B_IUE = 0;
  localparam int B_EXTERNAL_PERIOD_RESET_CTL = 1;
  localparam int B_CAM = 2;
  localparam int B_TIME_BASE_SOURCE_SEL = 3;
  localparam int B_DTC_LO = 6;
  localparam int B_ITB = 9;
  localparam int B_ENABLE = 15;
  // Blanking control fields
  localparam int B_BPLL = 0;
  localparam int B_BPLH = 1;
  localparam int B_BLANK_WHILE_HIGH_OUT_LOW = 2;
  localparam int B_BLANK_WHILE_HIGH_OUT_HIGH = 3;
  localparam int B_BCL = 4;
  localparam int B_BCH = 5;
  localparam int B_CLLEB = 10;
  localparam int B_FLTLEB = 11;
  localparam int B_PLF = 12;
  localparam int B_PLR = 13;
  localparam int B_PHF = 14;
  localparam int B_PHR = 15;
  // Interrupt status bits
  localparam int IRQ_W = 4;
  localparam int I_PERIOD = 0;
  localparam int I_FAULT = 1;
  localparam int I_CURLIM = 2;
  localparam int I_XRESET = 3;
  localparam int CENTER_LSB = 3;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  typedef enum logic [1:0] {
    PWMCEB_DT_POS = 2'b00,
    PWMCEB_DT_NEG = 2'b01,
    PWMCEB_DT_OFF = 2'b10,
    PWMCEB_DT_RSV = 2'b11
  } pwmceb_dt_t;
endpackage : pwmceb_pkg

//--- core/pwmceb_top.sv
// PWM generator with mode control, dead time, update control, blanking and interrupts
// How it works
// - Dead-time select gives positive dead time at 00, negative in complementary mode at 01, none at 10, 11 reserved.
// - Time base select set takes sync and clock enable from the secondary master base, clear from the primary.
// - Centre-align enable set gives an up/down centre-aligned waveform, clear an edge-aligned one.
// - Centre-align enable only counts when independent time base is set, otherwise operation stays edge aligned.
// - External period reset set with independent time base and current-limit mode off lets an active current limit restart the time base.
// - Immediate update set makes duty, phase, dead time and period writes active at once, else at period end or at once while the generator is disabled.
// - Centre-aligned operation ignores the three low bits of duty, phase and dead time.
// - Four enables let rising or falling edges of the high or low output start the blanking counter.
// - Blank-on-high and blank-on-low qualifiers blank the inputs while the selected blanking signal is high or low.
// - The blanking signal is picked by a four-bit source select field of the auxiliary control register.
`timescale 1ns/1ps
module pwmceb_top
  import pwmceb_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic primary_tick_in,
  input wire logic primary_sync_in,
  input wire logic secondary_tick_in,
  input wire logic secondary_sync_in,
  input wire logic current_limit_mode_in,
  input wire logic fault_pin_in,
  input wire logic curlim_pin_in,
  input wire logic [SRC_W-1:0] blank_sources_in,
  output logic high_side_output_out,
  output logic low_side_output_out,
  output logic fault_out,
  output logic curlim_out,
  output logic irq_out
);
  typedef struct packed {
    logic [DATA_W-1:0] gen_ctrl;
    logic [DATA_W-1:0] blank_ctrl;
    logic [DATA_W-1:0] aux_ctrl;
    logic [DATA_W-1:0] period_buf;
    logic [DATA_W-1:0] duty_buf;
    logic [DATA_W-1:0] phase_buf;
    logic [DATA_W-1:0] dead_buf;
    logic [DATA_W-1:0] blank_len;
    logic [DATA_W-1:0] period_act;
    logic [DATA_W-1:0] duty_act;
    logic [DATA_W-1:0] phase_act;
    logic [DATA_W-1:0] dead_act;
    logic [CNT_W-1:0] tb_cnt;
    logic down;
    logic [CNT_W-1:0] dt_cnt;
    logic raw_d;
    logic high_q;
    logic low_q;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [DATA_W-1:0] rdata;
    logic [1:0] flt_sync;
    logic [1:0] cl_sync;
    logic [SRC_W-1:0] src_s1;
    logic [SRC_W-1:0] src_s2;
  } pwmceb_st_t;
  pwmceb_st_t st_reg, st_next;
  pwmceb_blank_if bif();
  logic tick;
  logic sync;
  logic independent_time_base;
  logic center;
  logic xreset;
  logic period_end;
  logic raw;
  logic [DATA_W-1:0] duty_e;
  logic [DATA_W-1:0] dead_e;
  logic [IRQ_W-1:0] ev;
  pwmceb_dt_t dtm;
  // Clears the low bits that centre-aligned operation ignores
  function automatic logic [DATA_W-1:0] coarse(input logic [DATA_W-1:0] v, input logic ca);
    coarse = ca ? {v[DATA_W-1:CENTER_LSB], {CENTER_LSB{1'b0}}} : v;
  endfunction : coarse
  pwmceb_blank u_blank (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .bi(bif)
  );
  assign bif.high_out = st_reg.high_q;
  assign bif.low_out = st_reg.low_q;
  assign bif.blank_ctrl = st_reg.blank_ctrl;
  assign bif.blank_len = st_reg.blank_len;
  assign bif.blank_sel_level = st_reg.src_s2[st_reg.aux_ctrl[3:0]];
  assign bif.fault_raw = st_reg.flt_sync[1];
  assign bif.curlim_raw = st_reg.cl_sync[1];
  always_comb begin
    st_next = st_reg;
    st_next.flt_sync = {st_reg.flt_sync[0], fault_pin_in};
    st_next.cl_sync = {st_reg.cl_sync[0], curlim_pin_in};
    st_next.src_s1 = blank_sources_in;
    st_next.src_s2 = st_reg.src_s1;
    independent_time_base = st_reg.gen_ctrl[B_ITB];
    center = independent_time_base && st_reg.gen_ctrl[B_CAM];
    tick = st_reg.gen_ctrl[B_TIME_BASE_SOURCE_SEL] ? secondary_tick_in : primary_tick_in;
    sync = st_reg.gen_ctrl[B_TIME_BASE_SOURCE_SEL] ? secondary_sync_in : primary_sync_in;
    // Current-limit mode must be off for the external restart to act
    xreset = st_reg.gen_ctrl[B_EXTERNAL_PERIOD_RESET_CTL] && independent_time_base && !current_limit_mode_in && bif.curlim_q;
    duty_e = coarse(st_reg.duty_act, center);
    dead_e = coarse(st_reg.dead_act, center);
    period_end = 1'b0;
    ev = '0;
    if (st_reg.gen_ctrl[B_ENABLE] && tick) begin
      if (xreset) begin
        st_next.tb_cnt = coarse(st_reg.phase_act, center);
        st_next.down = 1'b0;
        ev[I_XRESET] = 1'b1;
      end else if (!independent_time_base && sync) begin
        st_next.tb_cnt = coarse(st_reg.phase_act, center);
        st_next.down = 1'b0;
        period_end = 1'b1;
      end else if (center) begin
        if (!st_reg.down && st_reg.tb_cnt >= st_reg.period_act) begin
          st_next.down = 1'b1;
          st_next.tb_cnt = st_reg.tb_cnt - CNT_ONE;
        end else if (st_reg.down && st_reg.tb_cnt == '0) begin
          st_next.down = 1'b0;
          st_next.tb_cnt = CNT_ONE;
          period_end = 1'b1;
        end else begin
          st_next.tb_cnt = st_reg.down ? st_reg.tb_cnt - CNT_ONE : st_reg.tb_cnt + CNT_ONE;
        end
      end else if (st_reg.tb_cnt >= st_reg.period_act) begin
        st_next.tb_cnt = '0;
        st_next.down = 1'b0;
        period_end = 1'b1;
      end else begin
        st_next.tb_cnt = st_reg.tb_cnt + CNT_ONE;
      end
    end
    raw = st_reg.gen_ctrl[B_ENABLE] && (st_reg.tb_cnt < duty_e);
    dtm = pwmceb_dt_t'(st_reg.gen_ctrl[B_DTC_LO+1:B_DTC_LO]);
    st_next.raw_d = raw;
    if (raw != st_reg.raw_d) begin
      st_next.dt_cnt = dead_e;
    end else if (st_reg.dt_cnt != '0 && tick) begin
      st_next.dt_cnt = st_reg.dt_cnt - CNT_ONE;
    end
    case (dtm)
      PWMCEB_DT_POS: begin
        // Each output waits for the dead time after its own turn-on edge
        st_next.high_q = raw && (st_reg.raw_d && st_reg.dt_cnt == '0) && dead_e != '0 || raw && dead_e == '0;
        st_next.low_q = st_reg.gen_ctrl[B_ENABLE] && !raw &&
                        ((!st_reg.raw_d && st_reg.dt_cnt == '0) || dead_e == '0);
      end
      PWMCEB_DT_NEG: begin
        // Outputs overlap by the dead time after each edge
        st_next.high_q = raw || (st_reg.raw_d != raw ? 1'b0 : 1'b0) || (!raw && st_reg.dt_cnt != '0);
        st_next.low_q = st_reg.gen_ctrl[B_ENABLE] && (!raw || st_reg.dt_cnt != '0);
      end
      PWMCEB_DT_OFF: begin
        st_next.high_q = raw;
        st_next.low_q = st_reg.gen_ctrl[B_ENABLE] && !raw;
      end
      default: begin
        st_next.high_q = 1'b0;
        st_next.low_q = 1'b0;
      end
    endcase
    if (st_reg.gen_ctrl[B_IUE] || period_end || !st_reg.gen_ctrl[B_ENABLE]) begin
      st_next.period_act = st_reg.period_buf;
      st_next.duty_act = st_reg.duty_buf;
      st_next.phase_act = st_reg.phase_buf;
      st_next.dead_act = st_reg.dead_buf;
    end
    ev[I_PERIOD] = period_end;
    ev[I_FAULT] = bif.fault_q;
    ev[I_CURLIM] = bif.curlim_q;
    st_next.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        OFS_GEN_CTRL: st_next.rdata = st_reg.gen_ctrl;
        OFS_BLANK_CTRL: st_next.rdata = st_reg.blank_ctrl;
        OFS_AUX_CTRL: st_next.rdata = st_reg.aux_ctrl;
        OFS_PERIOD: st_next.rdata = st_reg.period_buf;
        OFS_DUTY: st_next.rdata = st_reg.duty_buf;
        OFS_PHASE: st_next.rdata = st_reg.phase_buf;
        OFS_DEAD: st_next.rdata = st_reg.dead_buf;
        OFS_BLANK_LEN: st_next.rdata = st_reg.blank_len;
        OFS_IRQ_STAT: st_next.rdata = {12'h000, st_reg.irq_stat};
        OFS_IRQ_MASK: st_next.rdata = {12'h000, st_reg.irq_mask};
        OFS_STATUS: st_next.rdata = st_reg.tb_cnt;
        default: st_next.rdata = '0;
      endcase
    end
    if (wr_in) begin
      case (addr_in)
        OFS_GEN_CTRL: st_next.gen_ctrl = wdata_in & GEN_CTRL_MASK;
        OFS_BLANK_CTRL: st_next.blank_ctrl = wdata_in & BLANK_CTRL_MASK;
        OFS_AUX_CTRL: st_next.aux_ctrl = wdata_in & AUX_CTRL_MASK;
        OFS_PERIOD: st_next.period_buf = wdata_in;
        OFS_DUTY: st_next.duty_buf = wdata_in;
        OFS_PHASE: st_next.phase_buf = wdata_in;
        OFS_DEAD: st_next.dead_buf = wdata_in;
        OFS_BLANK_LEN: st_next.blank_len = wdata_in;
        OFS_IRQ_MASK: st_next.irq_mask = wdata_in[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    // Write one clears, a new event in the same cycle wins
    if (wr_in && addr_in == OFS_IRQ_STAT) begin
      st_next.irq_stat = (st_reg.irq_stat & ~wdata_in[IRQ_W-1:0]) | ev;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | ev;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign rdata_out = st_reg.rdata;
  assign high_side_output_out = st_reg.high_q;
  assign low_side_output_out = st_reg.low_q;
  assign fault_out = bif.fault_q;
  assign curlim_out = bif.curlim_q;
  assign irq_out = |(st_reg.irq_stat & st_reg.irq_mask);
endmodule : pwmceb_top

//--- testbench/pwmceb_chk.sv
// Port checker of the PWM control and blanking block
`timescale 1ns/1ps
module pwmceb_chk
  import pwmceb_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic [SRC_W-1:0] blank_sources_in,
  input wire logic fault_pin_in,
  input wire logic high_side_output_out,
  input wire logic low_side_output_out,
  input wire logic fault_out,
  input wire logic irq_out
);
  logic [DATA_W-1:0] gen_reg, blk_reg, aux_reg, len_reg;
  logic [IRQ_W-1:0] msk_reg;
  logic src_sel;
  assign src_sel = blank_sources_in[aux_reg[3:0]];
  // Shadow copies of the control registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      gen_reg <= RST_VAL;
      blk_reg <= RST_VAL;
      aux_reg <= RST_VAL;
      len_reg <= RST_VAL;
      msk_reg <= '0;
    end else if (wr_in) begin
      if (addr_in == OFS_GEN_CTRL) gen_reg <= wdata_in & GEN_CTRL_MASK;
      if (addr_in == OFS_BLANK_CTRL) blk_reg <= wdata_in & BLANK_CTRL_MASK;
      if (addr_in == OFS_AUX_CTRL) aux_reg <= wdata_in & AUX_CTRL_MASK;
      if (addr_in == OFS_BLANK_LEN) len_reg <= wdata_in;
      if (addr_in == OFS_IRQ_MASK) msk_reg <= wdata_in[IRQ_W-1:0];
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data not zero outside a read");
  gen_rback_a: assert property ($past(rd_in) && $past(addr_in) == OFS_GEN_CTRL |-> rdata_out == $past(gen_reg))
    else $error("generator control read back wrong");
  blk_rback_a: assert property ($past(rd_in) && $past(addr_in) == OFS_BLANK_CTRL |-> rdata_out == $past(blk_reg))
    else $error("blanking control read back wrong");
  dt_rsv_a: assert property (gen_reg[7:6] == 2'b11 && $past(gen_reg[7:6]) == 2'b11 |-> ##1 !high_side_output_out && !low_side_output_out)
    else $error("outputs active with reserved dead time");
  fault_pass_a: assert property (!blk_reg[B_FLTLEB] && !$past(blk_reg[B_FLTLEB]) |-> fault_out == $past(fault_pin_in, 2))
    else $error("fault input not passed through");
  blank_lvl_a: assert property (blk_reg[B_FLTLEB] && aux_reg == $past(aux_reg, 2) && ((blk_reg[B_BCH] && $past(src_sel, 2))
    || (blk_reg[B_BCL] && !$past(src_sel, 2))) |-> !fault_out)
    else $error("fault not blanked by selected signal");
  out_state_a: assert property (blk_reg[B_FLTLEB] && blk_reg[B_BLANK_WHILE_HIGH_OUT_HIGH] && high_side_output_out && $past(high_side_output_out)
    |-> !fault_out)
    else $error("fault not blanked while high output high");
  edge_trig_a: assert property ($rose(high_side_output_out) && blk_reg[B_PHR] && blk_reg[B_FLTLEB] && len_reg >= 16'h0004
    |-> ##[1:3] !fault_out)
    else $error("rising edge did not start blanking");
  irq_mask_a: assert property (msk_reg == '0 && $past(msk_reg) == '0 |-> !irq_out)
    else $error("interrupt raised while all masked");
  cov_irq: cover property ($rose(irq_out));
  cov_edge: cover property ($rose(high_side_output_out) && blk_reg[B_PHR]);
  cov_blank: cover property ($past(fault_pin_in, 2) && !fault_out);
endmodule : pwmceb_chk
bind pwmceb_top pwmceb_chk u_chk (.ref_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .blank_sources_in, .fault_pin_in, .high_side_output_out, .low_side_output_out, .fault_out, .irq_out);

//--- testbench/pwmceb_stage.sv
// Power stage model: drives fault and current-limit sense pins
`timescale 1ns/1ps
module pwmceb_stage (
  input wire logic clk_in,
  input wire logic high_in,
  input wire logic low_in,
  input wire logic fault_cmd_in,
  input wire logic curlim_cmd_in,
  output logic fault_pin_out,
  output logic curlim_pin_out
);
  // Both switches on is a shoot-through and trips the fault sense
  always @(posedge clk_in) begin
    fault_pin_out <= fault_cmd_in | (high_in & low_in);
    curlim_pin_out <= curlim_cmd_in;
  end
endmodule : pwmceb_stage

//--- testbench/testbench.sv
// Self-checking bench of the PWM control and blanking block
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  import pwmceb_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata, got, s0;
  logic wr = 1'b0, rd = 1'b0, ptick = 1'b0, stick = 1'b0, clmode = 1'b0, fcmd = 1'b0, ccmd = 1'b0;
  logic [SRC_W-1:0] src = '0;
  logic fpin, cpin, hi, lo, fout, cout, irq;
  logic [ADDR_W-1:0] ofs [4] = '{OFS_GEN_CTRL, OFS_BLANK_CTRL, OFS_AUX_CTRL, 4'hf};
  logic [DATA_W-1:0] msk [4] = '{GEN_CTRL_MASK, BLANK_CTRL_MASK, AUX_CTRL_MASK, 16'h0000};
  int errors = 0, num_checks = 0, cyc = 0, hcnt = 0;
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  pwmceb_top dut (.ref_clk_in, .rst_in, .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .primary_tick_in(ptick), .primary_sync_in(1'b0), .secondary_tick_in(stick), .secondary_sync_in(1'b0),
    .current_limit_mode_in(clmode), .fault_pin_in(fpin), .curlim_pin_in(cpin), .blank_sources_in(src),
    .high_side_output_out(hi), .low_side_output_out(lo), .fault_out(fout), .curlim_out(cout), .irq_out(irq));
  pwmceb_stage stage (.clk_in(ref_clk_in), .high_in(hi), .low_in(lo), .fault_cmd_in(fcmd), .curlim_cmd_in(ccmd),
    .fault_pin_out(fpin), .curlim_pin_out(cpin));
  always @(posedge ref_clk_in) begin
    cyc++;
    if (hi === 1'b1) hcnt++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : idle
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask : wr_reg
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(posedge ref_clk_in);
    got = rdata;
  endtask : rd_reg
  task automatic blk_chk(input logic [DATA_W-1:0] b, input logic ef, input logic ec);
    wr_reg(OFS_BLANK_CTRL, b);
    idle(4);
    `CHK(fout, ef, "fault output")
    `CHK(cout, ec, "current-limit output")
  endtask : blk_chk
  initial begin
    idle(16);
    rst_in <= 1'b0;
    idle(1);
    for (int i = 0; i < 16; i++) begin
      rd_reg(i[ADDR_W-1:0]);
      `CHK(got, RST_VAL, "reset value")
    end
    foreach (ofs[i]) begin
      wr_reg(ofs[i], 16'hffff);
      rd_reg(ofs[i]);
      `CHK(got, msk[i], "register mask")
    end
    $display("register test done");
    wr_reg(OFS_PERIOD, 16'h0010);
    wr_reg(OFS_DUTY, 16'h0008);
    ptick <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFS_GEN_CTRL, 16'h8200 | (16'(c) << B_DTC_LO));
      idle(1);
      hcnt = 0;
      idle(64);
      `CHK(hcnt != 0, c != 3, "dead time code")
    end
    $display("dead time test done");
    ptick <= 1'b0;
    stick <= 1'b1;
    for (int m = 1; m >= 0; m--) begin
      wr_reg(OFS_GEN_CTRL, 16'h8000 | (16'(m) << B_TIME_BASE_SOURCE_SEL));
      rd_reg(OFS_STATUS);
      s0 = got;
      idle(5);
      rd_reg(OFS_STATUS);
      `CHK(got != s0, m == 1, "time base source")
    end
    stick <= 1'b0;
    $display("time base test done");
    rst_in <= 1'b1;
    idle(2);
    rst_in <= 1'b0;
    idle(1);
    wr_reg(OFS_PERIOD, 16'h0064);
    wr_reg(OFS_GEN_CTRL, 16'h8280);
    wr_reg(OFS_DUTY, 16'h0032);
    idle(4);
    `CHK(hi, 1'b0, "duty held until period end")
    `CHK(lo, 1'b1, "low output on while high off")
    wr_reg(OFS_GEN_CTRL, 16'h8281);
    idle(4);
    `CHK(hi, 1'b1, "duty applied at once")
    `CHK(lo, 1'b0, "low output off while high on")
    $display("update test done");
    fcmd <= 1'b1;
    ccmd <= 1'b1;
    wr_reg(OFS_AUX_CTRL, 16'h0005);
    blk_chk(16'h0000, 1'b1, 1'b1);
    src <= 16'h0020;
    blk_chk(16'h0820, 1'b0, 1'b1);
    src <= 16'hffdf;
    blk_chk(16'h0820, 1'b1, 1'b1);
    blk_chk(16'h0810, 1'b0, 1'b1);
    blk_chk(16'h0808, 1'b0, 1'b1);
    blk_chk(16'h0804, 1'b1, 1'b1);
    blk_chk(16'h0408, 1'b1, 1'b0);
    wr_reg(OFS_BLANK_LEN, 16'h0014);
    for (int e = 1; e >= 0; e--) begin
      wr_reg(OFS_DUTY, 16'h0000);
      blk_chk(16'h0800 | (16'(e) << B_PHR), 1'b1, 1'b1);
      wr_reg(OFS_DUTY, 16'h0032);
      idle(3);
      `CHK(fout, e == 0, "blanking after rising edge")
      idle(30);
      `CHK(fout, 1'b1, "blanking window ended")
    end
    fcmd <= 1'b0;
    ccmd <= 1'b0;
    wr_reg(OFS_BLANK_CTRL, 16'h0000);
    $display("blanking test done");
    clmode <= 1'b0;
    ptick <= 1'b1;
    wr_reg(OFS_IRQ_MASK, 16'h0008);
    for (int x = 1; x >= 0; x--) begin
      wr_reg(OFS_GEN_CTRL, 16'h8281 | (16'(x) << B_EXTERNAL_PERIOD_RESET_CTL));
      wr_reg(OFS_IRQ_STAT, 16'h000f);
      ccmd <= 1'b1;
      idle(4);
      ccmd <= 1'b0;
      idle(4);
      rd_reg(OFS_IRQ_STAT);
      `CHK(got[I_XRESET], x == 1, "external period reset")
      `CHK(irq, x == 1, "interrupt level")
      wr_reg(OFS_IRQ_MASK, 16'h0000);
      `CHK(irq, 1'b0, "interrupt masked")
      wr_reg(OFS_IRQ_STAT, 16'h000f);
      wr_reg(OFS_IRQ_MASK, 16'h0008);
      `CHK(irq, 1'b0, "interrupt cleared")
    end
    $display("interrupt test done");
    wr_reg(OFS_PERIOD, 16'h0010);
    for (int m = 0; m < 2; m++) begin
      wr_reg(OFS_GEN_CTRL, 16'h0000);
      wr_reg(OFS_DUTY, 16'h0007);
      wr_reg(OFS_GEN_CTRL, 16'h8085 | (16'(m) << B_ITB));
      idle(1);
      hcnt = 0;
      idle(40);
      `CHK(hcnt != 0, m == 0, "centre alignment and duty low bits")
    end
    $display("centre test done");
    conclude();
  end
endmodule : testbench
